//--- src/iox_pkg.sv
// Shared constants, state encoding and state record for the four-bit I/O expander
package iox_pkg;

  // Command byte values that select a register
  localparam logic [7:0] CMD_INPUT = 8'h00;
  localparam logic [7:0] CMD_OUTPUT = 8'h01;
  localparam logic [7:0] CMD_POLARITY = 8'h02;
  localparam logic [7:0] CMD_CONFIG = 8'h03;
  localparam logic [7:0] CMD_SPECIAL = 8'h50;

  // General call address and the one soft-reset data byte
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET_BYTE = 8'h06;

  // Special function register field positions and the interrupt pin index
  localparam int SFR_INT_BIT = 0;
  localparam int SFR_PU_OFF_BIT = 1;
  localparam int PIN3_IDX = 3;

  // Values after reset
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [3:0] OUT_RST = 4'hf;
  localparam logic [3:0] POL_RST = 4'h0;
  localparam logic [3:0] CFG_RST = 4'hf;
  localparam logic [3:0] IN_RST = 4'hf;
  localparam logic [1:0] SFR_RST = 2'h0;

  // Read-back fill for the unused upper nibble, and for the six unused upper bits of the special register
  localparam logic [3:0] HI_ONES = 4'hf;
  localparam logic [3:0] HI_ZERO = 4'h0;
  localparam logic [5:0] SFR_HI_ZERO = 6'h00;

  // Bit count of one byte on the bus
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // Synchroniser width: scl, sda and four port pins
  localparam int SYNC_W = 6;
  localparam logic [5:0] SYNC_RST = 6'h3f;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_RX = 4'h3,
    ST_RX_ACK = 4'h4,
    ST_TX = 4'h5,
    ST_TX_MACK = 4'h6,
    ST_GC_RX = 4'h7,
    ST_GC_ACK = 4'h8,
    ST_GC_WAIT = 4'h9
  } iox_state_t;

  typedef struct packed {
    iox_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic gc;
    logic cmd_seen;
    logic mack;
    logic [7:0] cmd;
    logic [3:0] outr;
    logic [3:0] pol;
    logic [3:0] cfg;
    logic [1:0] sfr;
    logic [3:0] inr;
    logic scl_prev;
    logic sda_prev;
    logic sda_oe;
    logic [3:0] port_o;
    logic [3:0] port_oe;
    logic [3:0] port_pu;
  } iox_regs_t;

endpackage

//--- src/iox_sync_if.sv
// Carrier between the expander core and its input synchroniser
`timescale 1ns/1ps
interface iox_sync_if #(
  parameter int W = 6
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport user (output raw, input sync);
  modport syncer (input raw, output sync);
endinterface

//--- src/iox_sync.sv
// Two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module iox_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  iox_sync_if.syncer sy
);
  // Stage 0 feeds only stage 1; idle-high reset avoids a false start
  logic [1:0][W-1:0] st_q;
  logic [1:0][W-1:0] st_d;

  always_comb begin
    st_d[0] = sy.raw;
    st_d[1] = st_q[0];
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign sy.sync = st_q[1];
endmodule // iox_sync

//--- src/iox_expander.sv
// Four-bit I/O expander core: bus target, registers, ports and change interrupt
`timescale 1ns/1ps
module iox_expander #(
  parameter logic [6:0] OWN_ADDR = 7'h20 // Arbitrary target address
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic [3:0] i_port,
  output logic [3:0] o_port,
  output logic [3:0] o_port_oe,
  output logic [3:0] o_port_pu
);
  iox_pkg::iox_regs_t q;
  iox_pkg::iox_regs_t d;
  logic scl;
  logic sda;
  logic [3:0] pins;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic soft_rst;
  logic int_mode;
  logic pu_off;
  logic int_low;
  logic [3:0] watch;
  logic [7:0] rd_byte;

  iox_sync_if #(.W(iox_pkg::SYNC_W)) sy ();

  // Pins cross into the system clock through two flops
  assign sy.raw = {i_scl, i_sda, i_port};

  iox_sync #(
    .W(iox_pkg::SYNC_W),
    .RST_VAL(iox_pkg::SYNC_RST)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .sy(sy)
  );

  // Read-back multiplexer, selected by the stored command
  always_comb begin
    case (q.cmd)
      iox_pkg::CMD_INPUT: rd_byte = {iox_pkg::HI_ONES, q.inr ^ q.pol};
      iox_pkg::CMD_OUTPUT: rd_byte = {iox_pkg::HI_ONES, q.outr};
      iox_pkg::CMD_POLARITY: rd_byte = {iox_pkg::HI_ZERO, q.pol};
      iox_pkg::CMD_CONFIG: rd_byte = {iox_pkg::HI_ONES, q.cfg};
      iox_pkg::CMD_SPECIAL: rd_byte = {iox_pkg::SFR_HI_ZERO, q.sfr};
      default: rd_byte = {iox_pkg::HI_ZERO, iox_pkg::HI_ZERO};
    endcase
  end

  // Whole next-state computation
  always_comb begin
    d = q;
    scl = sy.sync[5];
    sda = sy.sync[4];
    pins = sy.sync[3:0];
    scl_rise = scl & ~q.scl_prev;
    scl_fall = ~scl & q.scl_prev;
    // Start and stop are sda edges while scl stays high
    start_seen = scl & q.scl_prev & q.sda_prev & ~sda;
    stop_seen = scl & q.scl_prev & ~q.sda_prev & sda;
    d.scl_prev = scl;
    d.sda_prev = sda;
    soft_rst = 1'b0;

    case (q.st)
      iox_pkg::ST_IDLE: begin
        d.sda_oe = 1'b0;
      end
      iox_pkg::ST_ADDR: begin
        if (scl_rise) begin
          d.shreg = {q.shreg[6:0], sda};
          d.bitcnt = q.bitcnt + iox_pkg::CNT_ONE;
        end else if (scl_fall && q.bitcnt == iox_pkg::BYTE_BITS) begin
          if (q.shreg[7:1] == OWN_ADDR) begin
            d.sda_oe = 1'b1;
            d.rw = q.shreg[0];
            d.gc = 1'b0;
            d.cmd_seen = 1'b0;
            d.st = iox_pkg::ST_ADDR_ACK;
          end else if (q.shreg[7:1] == iox_pkg::GC_ADDR && !q.shreg[0]) begin
            d.sda_oe = 1'b1;
            d.gc = 1'b1;
            d.rw = 1'b0;
            d.st = iox_pkg::ST_ADDR_ACK;
          end else begin
            // Other targets: stay off the bus and leave the interrupt alone
            d.st = iox_pkg::ST_IDLE;
          end
        end
      end
      iox_pkg::ST_ADDR_ACK: begin
        // Capture on the acknowledge rise, just before read data leaves
        if (scl_rise && q.rw && q.cmd == iox_pkg::CMD_INPUT) begin
          d.inr = pins;
        end
        if (scl_fall) begin
          d.bitcnt = iox_pkg::CNT_ZERO;
          if (q.gc) begin
            d.sda_oe = 1'b0;
            d.st = iox_pkg::ST_GC_RX;
          end else if (q.rw) begin
            d.shreg = rd_byte;
            d.sda_oe = ~rd_byte[7];
            d.st = iox_pkg::ST_TX;
          end else begin
            d.sda_oe = 1'b0;
            d.st = iox_pkg::ST_RX;
          end
        end
      end
      iox_pkg::ST_RX: begin
        if (scl_rise) begin
          d.shreg = {q.shreg[6:0], sda};
          d.bitcnt = q.bitcnt + iox_pkg::CNT_ONE;
        end else if (scl_fall && q.bitcnt == iox_pkg::BYTE_BITS) begin
          if (!q.cmd_seen) begin
            d.cmd = q.shreg;
            d.cmd_seen = 1'b1;
          end else begin
            // Same register for every data byte; input register ignores writes
            case (q.cmd)
              iox_pkg::CMD_OUTPUT: d.outr = q.shreg[3:0];
              iox_pkg::CMD_POLARITY: d.pol = q.shreg[3:0];
              iox_pkg::CMD_CONFIG: d.cfg = q.shreg[3:0];
              iox_pkg::CMD_SPECIAL: d.sfr = q.shreg[1:0];
              default: d.outr = q.outr;
            endcase
          end
          d.sda_oe = 1'b1;
          d.st = iox_pkg::ST_RX_ACK;
        end
      end
      iox_pkg::ST_RX_ACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.bitcnt = iox_pkg::CNT_ZERO;
          d.st = iox_pkg::ST_RX;
        end
      end
      iox_pkg::ST_TX: begin
        if (scl_rise) begin
          d.bitcnt = q.bitcnt + iox_pkg::CNT_ONE;
        end else if (scl_fall) begin
          if (q.bitcnt == iox_pkg::BYTE_BITS) begin
            d.sda_oe = 1'b0;
            d.mack = 1'b0;
            d.st = iox_pkg::ST_TX_MACK;
          end else begin
            // Open-drain data: pull low only for a zero bit
            d.shreg = {q.shreg[6:0], 1'b0};
            d.sda_oe = ~q.shreg[6];
          end
        end
      end
      iox_pkg::ST_TX_MACK: begin
        if (scl_rise) begin
          if (!sda) begin
            d.mack = 1'b1;
            // A change right in this pulse can be swallowed by the capture
            if (q.cmd == iox_pkg::CMD_INPUT) begin
              d.inr = pins;
            end
          end else begin
            d.st = iox_pkg::ST_IDLE;
          end
        end else if (scl_fall && q.mack) begin
          d.shreg = rd_byte;
          d.sda_oe = ~rd_byte[7];
          d.bitcnt = iox_pkg::CNT_ZERO;
          d.st = iox_pkg::ST_TX;
        end
      end
      iox_pkg::ST_GC_RX: begin
        if (scl_rise) begin
          d.shreg = {q.shreg[6:0], sda};
          d.bitcnt = q.bitcnt + iox_pkg::CNT_ONE;
        end else if (scl_fall && q.bitcnt == iox_pkg::BYTE_BITS) begin
          if (q.shreg == iox_pkg::GC_RESET_BYTE) begin
            d.sda_oe = 1'b1;
            d.st = iox_pkg::ST_GC_ACK;
          end else begin
            d.st = iox_pkg::ST_IDLE;
          end
        end
      end
      iox_pkg::ST_GC_ACK: begin
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.st = iox_pkg::ST_GC_WAIT;
        end
      end
      iox_pkg::ST_GC_WAIT: begin
        // A stop has one clock rise and no fall; a fall means a second byte, so drop the message
        if (scl_fall) begin
          d.st = iox_pkg::ST_IDLE;
        end
      end
      default: begin
        d.st = iox_pkg::ST_IDLE;
      end
    endcase

    // Start wins from any state, a repeated start cancels a soft reset
    if (start_seen) begin
      d.st = iox_pkg::ST_ADDR;
      d.bitcnt = iox_pkg::CNT_ZERO;
      d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      soft_rst = (q.st == iox_pkg::ST_GC_WAIT);
      d.st = iox_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end

    if (soft_rst) begin
      d.cmd = iox_pkg::CMD_RST;
      d.outr = iox_pkg::OUT_RST;
      d.pol = iox_pkg::POL_RST;
      d.cfg = iox_pkg::CFG_RST;
      d.sfr = iox_pkg::SFR_RST;
      d.inr = iox_pkg::IN_RST;
    end

    // Change detect against the captured value, input pins only
    int_mode = d.sfr[iox_pkg::SFR_INT_BIT];
    pu_off = d.sfr[iox_pkg::SFR_PU_OFF_BIT];
    watch = d.cfg;
    watch[iox_pkg::PIN3_IDX] = d.cfg[iox_pkg::PIN3_IDX] & ~int_mode;
    // Level compare, so a pin going back clears it and each new edge sets it
    int_low = int_mode & (|((pins ^ d.inr) & watch));

    // Pin drivers: cfg bit 1 means input
    d.port_oe = ~d.cfg;
    d.port_o = d.outr;
    d.port_pu = d.cfg & {4{~pu_off}};
    if (int_mode) begin
      d.port_oe[iox_pkg::PIN3_IDX] = int_low;
      d.port_o[iox_pkg::PIN3_IDX] = 1'b0;
      d.port_pu[iox_pkg::PIN3_IDX] = ~pu_off;
    end
  end

  // State register; reset leaves all pins inputs with pull-ups on
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q.st <= iox_pkg::ST_IDLE;
      q.bitcnt <= iox_pkg::CNT_ZERO;
      q.shreg <= 8'h00;
      q.rw <= 1'b0;
      q.gc <= 1'b0;
      q.cmd_seen <= 1'b0;
      q.mack <= 1'b0;
      q.cmd <= iox_pkg::CMD_RST;
      q.outr <= iox_pkg::OUT_RST;
      q.pol <= iox_pkg::POL_RST;
      q.cfg <= iox_pkg::CFG_RST;
      q.sfr <= iox_pkg::SFR_RST;
      q.inr <= iox_pkg::IN_RST;
      q.scl_prev <= 1'b1;
      q.sda_prev <= 1'b1;
      q.sda_oe <= 1'b0;
      q.port_o <= iox_pkg::OUT_RST;
      q.port_oe <= 4'h0;
      q.port_pu <= 4'hf;
    end else begin
      q <= d;
    end
  end

  // Open-drain sda only ever pulls low
  assign o_sda = 1'b0;
  assign o_sda_oe = q.sda_oe;
  assign o_port = q.port_o;
  assign o_port_oe = q.port_oe;
  assign o_port_pu = q.port_pu;
endmodule // iox_expander

//--- bench/iox_expander_asserts.sv
// Pin-level checker for the four-bit expander, bound to its top module
`timescale 1ns/1ps
module iox_expander_chk (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic [3:0] i_port,
  input wire logic [3:0] o_port,
  input wire logic [3:0] o_port_oe,
  input wire logic [3:0] o_port_pu
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Bus data line is open drain: only the enable moves
  a_sda_open_drain: assert property (o_sda == 1'b0)
    else $error("sda value is not the pull-low level");
  a_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
    else $error("sda enable moved while scl high");
  a_sda_hold_high: assert property ($rose(i_scl) |-> $stable(o_sda_oe) [*4])
    else $error("sda enable not held over scl high");
  // Reset leaves every pin an input with pull-up
  a_reset_state: assert property ($rose(i_rst_n) |-> o_port_oe == 4'h0 && o_port_pu == 4'hf && !o_sda_oe)
    else $error("pins not at default after reset");
  // Pull-ups only on undriven pins 0 to 2, all switched by one bit
  a_pu_outputs: assert property ((o_port_oe[2:0] & o_port_pu[2:0]) == 3'h0)
    else $error("pull-up on a driven pin");
  a_pu_shared: assert property (|(~o_port_oe[2:0] & o_port_pu[2:0]) |-> (~o_port_oe[2:0] & ~o_port_pu[2:0]) == 3'h0)
    else $error("input pull-ups disagree");
  // Pin three as interrupt: pulled low only, pull-up follows the others
  a_int_pu_follow: assert property (o_port_oe[3] && o_port_pu[3] |-> (~o_port_oe[2:0] & ~o_port_pu[2:0]) == 3'h0)
    else $error("interrupt pull-up differs from inputs");
  a_int_pulls_low: assert property (o_port_oe[3] && o_port_pu[3] |-> o_port[3] == 1'b0)
    else $error("interrupt pin driven high");

  // Main scenarios reached
  c_int_seen: cover property (o_port_oe[3] && o_port_pu[3]);
  c_ack_seen: cover property ($rose(o_sda_oe));
  c_out_drive: cover property (o_port_oe[1:0] == 2'h3);
endmodule // iox_expander_chk

bind iox_expander iox_expander_chk iox_expander_chk_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_port(i_port), .o_port(o_port),
  .o_port_oe(o_port_oe), .o_port_pu(o_port_pu));

//--- bench/iox_ctl_model.sv
// Behavioural bus controller driving clock and data toward the expander
`timescale 1ns/1ps
module iox_ctl_model (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  localparam time QTR = 200ns;

  // Both lines idle high; clock stands still between frames
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Start or repeated start; waits so the target has released data first
  task automatic start();
    #QTR o_sda = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda = 1'b0;
    #QTR o_scl = 1'b0;
  endtask

  // Stop, leaving the bus idle high
  task automatic stop();
    #QTR o_sda = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda = 1'b1;
    #QTR;
  endtask

  // One clock: data set mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic s);
    #QTR o_sda = b;
    #QTR o_scl = 1'b1;
    #QTR s = i_sda;
    #QTR o_scl = 1'b0;
  endtask

  // Byte MSB first plus the ninth acknowledge clock
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(m, a);
  endtask
endmodule // iox_ctl_model

//--- bench/iox_expander_test.sv
// Self-checking bench: controller model drives registers, bench drives the pins
`timescale 1ns/1ps
module iox_expander_test;
  localparam logic [6:0] ADR = 7'h20; // Arbitrary target address
  logic sys_clk, rst_n, scl, ctl_sda, sda, o_sda, sda_oe;
  logic [3:0] pins, port_o, port_oe, port_pu, ext, ext_en;
  int fail_count, comparisons;
  logic [7:0] cmd [4] = '{iox_pkg::CMD_OUTPUT, iox_pkg::CMD_POLARITY, iox_pkg::CMD_CONFIG, iox_pkg::CMD_SPECIAL};
  logic [7:0] dflt [4] = '{8'hff, 8'h00, 8'hff, 8'h00};

  // Wired-AND data line; pins favour the device, then bench, then pull-up
  assign sda = ctl_sda & (sda_oe ? o_sda : 1'b1);
  assign pins = (port_oe & port_o) | (~port_oe & ((ext_en & ext) | (~ext_en & (port_pu | ~ext))));

  iox_expander #(.OWN_ADDR(ADR)) iox_expander_inst (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_scl(scl),
    .i_sda(sda), .o_sda(o_sda), .o_sda_oe(sda_oe), .i_port(pins), .o_port(port_o), .o_port_oe(port_oe),
    .o_port_pu(port_pu));
  iox_ctl_model iox_ctl_model_inst (.o_scl(scl), .o_sda(ctl_sda), .i_sda(sda));

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Send a byte and compare the acknowledge bit (0 = taken)
  task automatic tx(input logic [7:0] d, input logic e);
    logic [7:0] r;
    logic a;
    iox_ctl_model_inst.xfer(d, 1'b1, r, a);
    chk("ack", {7'h0, e}, {7'h0, a});
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    iox_ctl_model_inst.start();
    tx({ADR, 1'b0}, 1'b0);
    tx(c, 1'b0);
    tx(d, 1'b0);
    iox_ctl_model_inst.stop();
  endtask

  // Two bytes per read: the second must repeat the same register
  task automatic rd(input logic [7:0] c, input logic [7:0] e, input logic [7:0] m);
    logic [7:0] r;
    logic a;
    iox_ctl_model_inst.start();
    tx({ADR, 1'b0}, 1'b0);
    tx(c, 1'b0);
    iox_ctl_model_inst.start();
    tx({ADR, 1'b1}, 1'b0);
    iox_ctl_model_inst.xfer(8'hff, 1'b0, r, a);
    chk("rd_first", e & m, r & m);
    iox_ctl_model_inst.xfer(8'hff, 1'b1, r, a);
    chk("rd_again", e & m, r & m);
    iox_ctl_model_inst.stop();
  endtask

  // Interrupt is pin three enable; bounded wait for it to settle
  task automatic wint(input logic e);
    for (int k = 0; k < 20 && port_oe[3] !== e; k++) @(negedge sys_clk);
    chk("int_pin", {7'h0, e}, {7'h0, port_oe[3]});
  endtask

  // Hang guard
  initial begin
    #3ms;
    fail_count++;
    finish_test();
  end

  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    ext = 4'h9;
    ext_en = 4'hf;
    fail_count = 0;
    comparisons = 0;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("port_oe", 8'h00, {4'h0, port_oe});
    chk("port_pu", 8'h0f, {4'h0, port_pu});
    for (int i = 0; i < 4; i++) rd(cmd[i], dflt[i], 8'hff);
    wr(iox_pkg::CMD_CONFIG, 8'hfc);
    wr(iox_pkg::CMD_OUTPUT, 8'h02);
    wr(iox_pkg::CMD_POLARITY, 8'h05);
    chk("port_oe", 8'h03, {4'h0, port_oe});
    chk("port_o", 8'h02, {6'h0, port_o[1:0]});
    chk("port_pu", 8'h0c, {4'h0, port_pu});
    rd(iox_pkg::CMD_INPUT, 8'hff, 8'hff);
    wr(iox_pkg::CMD_SPECIAL, 8'h02);
    chk("port_pu", 8'h00, {4'h0, port_pu});
    rd(iox_pkg::CMD_SPECIAL, 8'h02, 8'hff);
    wr(iox_pkg::CMD_POLARITY, 8'h00);
    ext_en = 4'h7;
    wr(iox_pkg::CMD_SPECIAL, 8'h01);
    wint(1'b0);
    chk("port_pu", 8'h0c, {4'h0, port_pu});
    wr(iox_pkg::CMD_CONFIG, 8'hff);
    wint(1'b1);
    chk("int_level", 8'h00, {7'h0, pins[3]});
    ext = 4'h2;
    wint(1'b0);
    ext = 4'h0;
    wint(1'b1);
    iox_ctl_model_inst.start();
    tx({7'h21, 1'b0}, 1'b1);
    iox_ctl_model_inst.stop();
    wint(1'b1);
    rd(iox_pkg::CMD_INPUT, 8'hf0, 8'hf7);
    wint(1'b0);
    ext = 4'h4;
    wint(1'b1);
    iox_ctl_model_inst.start();
    tx(8'h00, 1'b0);
    tx(8'h07, 1'b1);
    iox_ctl_model_inst.stop();
    rd(iox_pkg::CMD_SPECIAL, 8'h01, 8'hff);
    iox_ctl_model_inst.start();
    tx(8'h00, 1'b0);
    tx(iox_pkg::GC_RESET_BYTE, 1'b0);
    iox_ctl_model_inst.stop();
    rd(iox_pkg::CMD_CONFIG, 8'hff, 8'hff);
    // Registers that held non-default values before the soft reset
    rd(iox_pkg::CMD_SPECIAL, 8'h00, 8'hff);
    rd(iox_pkg::CMD_OUTPUT, 8'hff, 8'hff);
    chk("port_oe", 8'h00, {4'h0, port_oe});
    chk("port_pu", 8'h0f, {4'h0, port_pu});
    finish_test();
  end
endmodule // iox_expander_test
